// *** port0_pin_config_regs.vh ***
// Register offsets, field positions, reset values and mode codes of the port-0 pin configuration.
`ifndef PORT0_PIN_CONFIG_REGS_VH
`define PORT0_PIN_CONFIG_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus (index times four)
// ----------------------------------------------------------------------
`define P0_IDX_CTRL_MID      8'hC7
`define P0_IDX_CTRL_LOW      8'hC8
`define P0_IDX_PULLUP        8'hC9
`define P0_IDX_CTRL_HIGH     8'hC6
`define P0_IDX_PORT_DATA     8'hC0
`define P0_ADDR_CTRL_MID     10'h31C
`define P0_ADDR_CTRL_LOW     10'h320
`define P0_ADDR_PULLUP       10'h324
`define P0_ADDR_CTRL_HIGH    10'h318
`define P0_ADDR_PORT_DATA    10'h300

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define P0_RST_CTRL_MID      8'h00
`define P0_RST_CTRL_LOW      8'h00
`define P0_RST_PULLUP        8'h00
`define P0_RST_CTRL_HIGH     8'h00
`define P0_RST_PORT_DATA     8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define P0_MID_PIN5_HI       7
`define P0_MID_PIN5_LO       6
`define P0_MID_PIN4_HI       5
`define P0_MID_PIN4_LO       3
`define P0_MID_PIN3_HI       2
`define P0_MID_PIN3_LO       0
`define P0_LOW_PIN2_HI       5
`define P0_LOW_PIN2_LO       4
`define P0_LOW_PIN1_HI       3
`define P0_LOW_PIN1_LO       2
`define P0_LOW_PIN0_HI       1
`define P0_LOW_PIN0_LO       0
`define P0_HIGH_PIN5_PP      0
`define P0_LOW_USED_MASK     8'h3F
`define P0_HIGH_USED_MASK    8'h01

// ----------------------------------------------------------------------
// Decoded pin modes
// ----------------------------------------------------------------------
`define P0_MODE_INPUT        3'h0
`define P0_MODE_OPEN_DRAIN   3'h1
`define P0_MODE_ALT_ANALOG   3'h2
`define P0_MODE_ALT_OUT      3'h3
`define P0_MODE_PUSH_PULL    3'h4
`define P0_MODE_ALT_IN       3'h5

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define P0_RESP_OKAY         2'h0
`define P0_RESP_SLVERR       2'h2

`endif

// *** pin_sync3.v ***
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/1ps

module pin_sync3 (
   input  wire i_clock,   // System clock.
   input  wire i_rst_b,   // Synchronous reset, active low.
   input  wire i_ce,      // Clock enable.
   input  wire i_pin,     // Asynchronous pin level.
   output wire o_level    // Filtered level.
);

   reg s1_ff;   // First stage, read only by the second.
   reg s2_ff;   // Second stage.
   reg s3_ff;   // Third stage.
   reg lvl_ff;  // Accepted level.

   // ----------------------------------------------------------------------
   // Shift chain and agreement filter
   // ----------------------------------------------------------------------
   // The level changes only once stages two and three agree.
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         s1_ff  <= 1'b0;
         s2_ff  <= 1'b0;
         s3_ff  <= 1'b0;
         lvl_ff <= 1'b0;
      end else if (i_ce) begin
         s1_ff <= i_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
         end
      end
   end

   assign o_level = lvl_ff;

endmodule

// *** pin_mode_decode.v ***
// Decoder from one pin's control field to its pad driver signals.
`timescale 1ns/1ps
`include "port0_pin_config_regs.vh"

module pin_mode_decode (
   input  wire [2:0] i_mode,      // Decoded pin mode.
   input  wire       i_data,      // Port data bit for the pin.
   input  wire       i_alt_out,   // Peripheral output for the alternative mode.
   output wire       o_pad_out,   // Level driven on the pad.
   output wire       o_pad_oe,    // High while the pad is driven.
   output wire       o_analog     // High when the analog channel owns the pad.
);

   // ----------------------------------------------------------------------
   // Drive selection
   // ----------------------------------------------------------------------
   // Open drain drives only a low; push-pull drives both levels.
   assign o_pad_out = (i_mode == `P0_MODE_ALT_OUT) ? i_alt_out :
                      (i_mode == `P0_MODE_OPEN_DRAIN) ? 1'b0 : i_data;
   assign o_pad_oe  = (i_mode == `P0_MODE_PUSH_PULL) |
                      (i_mode == `P0_MODE_ALT_OUT) |
                      ((i_mode == `P0_MODE_OPEN_DRAIN) & ~i_data);
   assign o_analog  = (i_mode == `P0_MODE_ALT_ANALOG);

endmodule

// *** port0_pin_config.v ***
// Port-0 pin configuration: control registers, pull-ups and pad drive over AXI4-Lite.
//
// Functional notes
// - Reset clears middle control register to zero.
// - Reset clears low control register to zero.
// - Pin-5 two-bit field selects four modes.
// - Pin-4 field: input, analog, serial clock.
// - Pin-3 field: input, analog, timer output.
// - Three-bit field top bit means push-pull.
// - Three-bit value 001 means open drain.
// - Pin-2 field: input, drain, analog, push-pull.
// - Pin-1 field: input, drain, suboscillator out.
// - Pin-0 field: input, drain, suboscillator in.
// - Pull-up register: one bit per pin.
// - High register bit 0 forces pin 5 push-pull.
// - Pull-up bit one connects the resistor.
// - Data drives outputs, reads inputs' pin state.
`timescale 1ns/1ps
`include "port0_pin_config_regs.vh"

module port0_pin_config (
   input  wire        i_clock,          // System clock, 10 MHz.
   input  wire        i_rst_b,          // Synchronous reset, active low.
   input  wire        i_ce,             // Clock enable; all state holds while low.
   input  wire [9:0]  i_awaddr,         // Write address.
   input  wire        i_awvalid,        // Write address valid.
   output wire        o_awready,        // Write address ready.
   input  wire [31:0] i_wdata,          // Write data.
   input  wire [3:0]  i_wstrb,          // Write byte strobes.
   input  wire        i_wvalid,         // Write data valid.
   output wire        o_wready,         // Write data ready.
   output wire [1:0]  o_bresp,          // Write response.
   output wire        o_bvalid,         // Write response valid.
   input  wire        i_bready,         // Write response ready.
   input  wire [9:0]  i_araddr,         // Read address.
   input  wire        i_arvalid,        // Read address valid.
   output wire        o_arready,        // Read address ready.
   output wire [31:0] o_rdata,          // Read data.
   output wire [1:0]  o_rresp,          // Read response.
   output wire        o_rvalid,         // Read data valid.
   input  wire        i_rready,         // Read data ready.
   input  wire [7:0]  i_pad_in,         // Pad levels of pins 0 to 7.
   output wire [5:0]  o_pad_out,        // Driven levels of pins 0 to 5.
   output wire [5:0]  o_pad_oe,         // Output enables of pins 0 to 5.
   output wire [7:0]  o_pullup_en,      // Pull-up connect per pin.
   output wire [5:0]  o_analog_sel,     // Analog channels 0..3 on pins 2..5, bits 2..5.
   input  wire        i_timer0_wave,    // Timer-0 wave output for pin 3.
   input  wire        i_timer1_wave,    // Timer-1 wave output for pin 5.
   input  wire        i_serial_clk,     // Serial clock output for pin 4.
   output wire        o_subosc_in_sel,  // Pin 0 given to the sub-oscillator input.
   output wire        o_subosc_out_sel, // Pin 1 given to the sub-oscillator output.
   output wire [5:0]  o_pin_level       // Synchronised pin levels for peripherals.
);

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   reg  [7:0]  ctrl_mid_ff;    // Middle control register, pins 3 to 5.
   reg  [7:0]  ctrl_low_ff;    // Low control register, pins 0 to 2.
   reg  [7:0]  ctrl_high_ff;   // High control register, bit 0 only.
   reg  [7:0]  pullup_ff;      // Pull-up enable register.
   reg  [7:0]  data_ff;        // Port data register.
   reg         aw_ff;          // Write address held.
   reg  [9:0]  awaddr_ff;      // Held write address.
   reg         w_ff;           // Write data held.
   reg  [31:0] wdata_ff;       // Held write data.
   reg  [3:0]  wstrb_ff;       // Held write strobes.
   reg         bvalid_ff;      // Write response pending.
   reg  [1:0]  bresp_ff;       // Write response code.
   reg         rvalid_ff;      // Read response pending.
   reg  [31:0] rdata_ff;       // Read data.
   reg  [1:0]  rresp_ff;       // Read response code.
   reg  [2:0]  mode [0:5];     // Decoded mode per pin.
   reg  [2:0]  mid_mode [0:1]; // Decoded three-bit fields, pins 3 and 4.
   reg  [31:0] nxt_rdata;      // Read data being selected.
   reg  [2:0]  fld;            // Three-bit field being decoded.
   reg         nxt_rok;        // Read address mapped.
   wire [7:0]  level;          // Filtered pad levels.
   wire [5:0]  alt_out;        // Peripheral outputs per pin.
   wire        do_write;       // Both write halves held, response free.
   wire        wr_hit;         // Write address mapped.
   wire [7:0]  wbyte;          // Byte lane 0 of held write data.
   wire [7:0]  pin_read;       // Port data register as seen by reads.
   integer     k;              // Loop index.

   // ----------------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------------
   // Turns each control field into a common mode code.
   always @* begin
      mid_mode[0] = 3'h0;
      mid_mode[1] = 3'h0;
      fld = 3'h0;
      for (k = 0; k < 2; k = k + 1) begin
         if (k == 0) begin
            fld = ctrl_mid_ff[`P0_MID_PIN3_HI:`P0_MID_PIN3_LO];
         end else begin
            fld = ctrl_mid_ff[`P0_MID_PIN4_HI:`P0_MID_PIN4_LO];
         end
         // Top bit set means push-pull whatever the low bits hold.
         if (fld[2]) begin
            mid_mode[k] = `P0_MODE_PUSH_PULL;
         end else if (fld[1:0] == 2'h1) begin
            mid_mode[k] = `P0_MODE_OPEN_DRAIN;
         end else if (fld[1:0] == 2'h2) begin
            mid_mode[k] = `P0_MODE_ALT_ANALOG;
         end else if (fld[1:0] == 2'h3) begin
            mid_mode[k] = `P0_MODE_ALT_OUT;
         end else begin
            mid_mode[k] = `P0_MODE_INPUT;
         end
      end
      mode[3] = mid_mode[0];
      mode[4] = mid_mode[1];
      // Pin 5: the high register bit overrides the two-bit field.
      if (ctrl_high_ff[`P0_HIGH_PIN5_PP]) begin
         mode[5] = `P0_MODE_PUSH_PULL;
      end else begin
         case (ctrl_mid_ff[`P0_MID_PIN5_HI:`P0_MID_PIN5_LO])
            2'h0:    mode[5] = `P0_MODE_INPUT;
            2'h1:    mode[5] = `P0_MODE_OPEN_DRAIN;
            2'h2:    mode[5] = `P0_MODE_ALT_ANALOG;
            default: mode[5] = `P0_MODE_ALT_OUT;
         endcase
      end
      case (ctrl_low_ff[`P0_LOW_PIN2_HI:`P0_LOW_PIN2_LO])
         2'h0:    mode[2] = `P0_MODE_INPUT;
         2'h1:    mode[2] = `P0_MODE_OPEN_DRAIN;
         2'h2:    mode[2] = `P0_MODE_ALT_ANALOG;
         default: mode[2] = `P0_MODE_PUSH_PULL;
      endcase
      case (ctrl_low_ff[`P0_LOW_PIN1_HI:`P0_LOW_PIN1_LO])
         2'h0:    mode[1] = `P0_MODE_INPUT;
         2'h1:    mode[1] = `P0_MODE_OPEN_DRAIN;
         2'h2:    mode[1] = `P0_MODE_ALT_IN;
         default: mode[1] = `P0_MODE_PUSH_PULL;
      endcase
      case (ctrl_low_ff[`P0_LOW_PIN0_HI:`P0_LOW_PIN0_LO])
         2'h0:    mode[0] = `P0_MODE_INPUT;
         2'h1:    mode[0] = `P0_MODE_OPEN_DRAIN;
         2'h2:    mode[0] = `P0_MODE_ALT_IN;
         default: mode[0] = `P0_MODE_PUSH_PULL;
      endcase
   end

   // Peripheral outputs routed to the pins that carry them.
   assign alt_out = {i_timer1_wave, i_serial_clk, i_timer0_wave, 3'h0};

   // ----------------------------------------------------------------------
   // Pad drivers and input synchronisers
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : pad
         // Push-pull and open-drain pins follow the port data register; alternative-output pins follow their peripheral.
         pin_mode_decode u_dec (
            .i_mode    (mode[g]),
            .i_data    (data_ff[g]),
            .i_alt_out (alt_out[g]),
            .o_pad_out (o_pad_out[g]),
            .o_pad_oe  (o_pad_oe[g]),
            .o_analog  (o_analog_sel[g])
         );
      end
      for (g = 0; g < 8; g = g + 1) begin : syn
         pin_sync3 u_sync (
            .i_clock (i_clock),
            .i_rst_b (i_rst_b),
            .i_ce    (i_ce),
            .i_pin   (i_pad_in[g]),
            .o_level (level[g])
         );
      end
   endgenerate

   // A one in the pull-up register connects the resistor.
   assign o_pullup_en      = pullup_ff;
   assign o_subosc_in_sel  = (mode[0] == `P0_MODE_ALT_IN);
   assign o_subosc_out_sel = (mode[1] == `P0_MODE_ALT_IN);
   assign o_pin_level      = level[5:0];

   // Pins 0 to 5 read their pad in input mode, their data bit otherwise; pins 6 and 7
   // are controlled elsewhere and always read their pad.
   generate
      for (g = 0; g < 6; g = g + 1) begin : rd
         assign pin_read[g] = (mode[g] == `P0_MODE_INPUT) ? level[g] : data_ff[g];
      end
   endgenerate
   assign pin_read[7:6] = level[7:6];

   // ----------------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------------
   assign o_awready = ~aw_ff;
   assign o_wready  = ~w_ff;
   assign o_bvalid  = bvalid_ff;
   assign o_bresp   = bresp_ff;
   assign do_write  = aw_ff & w_ff & ~bvalid_ff;
   assign wbyte     = wdata_ff[7:0];
   assign wr_hit    = (awaddr_ff == `P0_ADDR_CTRL_MID) |
                      (awaddr_ff == `P0_ADDR_CTRL_LOW) |
                      (awaddr_ff == `P0_ADDR_PULLUP) |
                      (awaddr_ff == `P0_ADDR_CTRL_HIGH) |
                      (awaddr_ff == `P0_ADDR_PORT_DATA);

   // Takes address and data in either order, writes once both are held.
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         // All registers to reset values.
         aw_ff        <= 1'b0;
         awaddr_ff    <= 10'h000;
         w_ff         <= 1'b0;
         wdata_ff     <= 32'h00000000;
         wstrb_ff     <= 4'h0;
         bvalid_ff    <= 1'b0;
         bresp_ff     <= `P0_RESP_OKAY;
         ctrl_mid_ff  <= `P0_RST_CTRL_MID;
         ctrl_low_ff  <= `P0_RST_CTRL_LOW;
         ctrl_high_ff <= `P0_RST_CTRL_HIGH;
         pullup_ff    <= `P0_RST_PULLUP;
         data_ff      <= `P0_RST_PORT_DATA;
      end else if (i_ce) begin
         // Take an address if none is held.
         if (i_awvalid && !aw_ff) begin
            aw_ff     <= 1'b1;
            awaddr_ff <= i_awaddr;
         end
         // Take write data if none is held.
         if (i_wvalid && !w_ff) begin
            w_ff     <= 1'b1;
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
         end
         if (do_write) begin
            // Commit the write and answer.
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? `P0_RESP_OKAY : `P0_RESP_SLVERR;
            // Only byte lane 0 carries register bits.
            if (wstrb_ff[0]) begin
               case (awaddr_ff)
                  `P0_ADDR_CTRL_MID:  ctrl_mid_ff  <= wbyte;
                  `P0_ADDR_CTRL_LOW:  ctrl_low_ff  <= wbyte & `P0_LOW_USED_MASK;
                  `P0_ADDR_CTRL_HIGH: ctrl_high_ff <= wbyte & `P0_HIGH_USED_MASK;
                  `P0_ADDR_PULLUP:    pullup_ff    <= wbyte;
                  `P0_ADDR_PORT_DATA: data_ff      <= wbyte;
                  default:            data_ff      <= data_ff;
               endcase
            end
         end else if (bvalid_ff && i_bready) begin
            // The master took the answer.
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------------
   assign o_arready = ~rvalid_ff;
   assign o_rvalid  = rvalid_ff;
   assign o_rdata   = rdata_ff;
   assign o_rresp   = rresp_ff;

   // Picks the read word and flags an unmapped address.
   always @* begin
      nxt_rdata = 32'h00000000;
      nxt_rok   = 1'b1;
      case (i_araddr)
         `P0_ADDR_CTRL_MID:  nxt_rdata = {24'h000000, ctrl_mid_ff};
         `P0_ADDR_CTRL_LOW:  nxt_rdata = {24'h000000, ctrl_low_ff};
         `P0_ADDR_CTRL_HIGH: nxt_rdata = {24'h000000, ctrl_high_ff};
         `P0_ADDR_PULLUP:    nxt_rdata = {24'h000000, pullup_ff};
         `P0_ADDR_PORT_DATA: nxt_rdata = {24'h000000, pin_read};
         default:            nxt_rok   = 1'b0;
      endcase
   end

   // Registers one read at a time; answer one cycle after the address.
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         // No answer pending after reset.
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= `P0_RESP_OKAY;
      end else if (i_ce) begin
         if (i_arvalid && !rvalid_ff) begin
            // Answer stands from the next edge.
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rok ? `P0_RESP_OKAY : `P0_RESP_SLVERR;
         end else if (rvalid_ff && i_rready) begin
            // The master took the answer.
            rvalid_ff <= 1'b0;
         end
      end
   end

endmodule

// *** port0_pin_config_checker.sv ***
// Concurrent checks on the ports of the port-0 pin configuration block.
`timescale 1ns/1ps
module port0_pin_config_checker (
   input wire        i_clock,
   input wire        i_rst_b,
   input wire        i_awvalid,
   input wire        o_awready,
   input wire        i_wvalid,
   input wire        o_wready,
   input wire [1:0]  o_bresp,
   input wire        o_bvalid,
   input wire        i_bready,
   input wire        i_arvalid,
   input wire        o_arready,
   input wire [31:0] o_rdata,
   input wire [1:0]  o_rresp,
   input wire        o_rvalid,
   input wire        i_rready,
   input wire [5:0]  o_pad_oe,
   input wire [7:0]  o_pullup_en,
   input wire [5:0]  o_analog_sel,
   input wire        o_subosc_in_sel
);
   // ----
   // Clocking and reset shared by all checks.
   // ----
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);

   // Bus answers come at the latency the slave promises and stand until taken.
   a_read_latency: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer not one cycle after the address");
   a_write_latency: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
      else $error("write answer not two cycles after address and data");
   a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
      else $error("read answer dropped before it was taken");
   a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped before it was taken");
   a_arready_block: assert property (o_rvalid |-> !o_arready)
      else $error("read address taken while a read answer waits");
   // After reset every pad floats and every pull-up is off.
   a_reset_clear: assert property ($rose(i_rst_b) |-> o_pad_oe == 6'h00 && o_pullup_en == 8'h00)
      else $error("pads or pull-ups active right after reset");
   // Configuration outputs move only with a completed register write.
   a_pullup_cause: assert property ($changed(o_pullup_en) |-> $rose(o_bvalid))
      else $error("pull-ups changed without a write");
   a_analog_cause: assert property ($changed(o_analog_sel) |-> $rose(o_bvalid))
      else $error("analog selection changed without a write");
   // Pins handed to an input function are never driven.
   a_subosc_float: assert property (o_subosc_in_sel |-> !o_pad_oe[0])
      else $error("sub-oscillator input pin is driven");
   a_analog_float: assert property (o_analog_sel != 6'h00 |-> (o_analog_sel & o_pad_oe) == 6'h00)
      else $error("analog pin is driven");
endmodule

bind port0_pin_config port0_pin_config_checker u_chk (.*);

// *** port0_pins_model.sv ***
// Model of the pads, pull-up resistors and peripheral wave sources around port 0.
`timescale 1ns/1ps
module port0_pins_model (
   input  wire [0:0] i_clock,     // System clock.
   input  wire [5:0] i_pad_out,   // Levels driven by the block.
   input  wire [5:0] i_pad_oe,    // Drive enables from the block.
   input  wire [7:0] i_pullup_en, // Pull-up connects from the block.
   output logic [7:0] o_pad_in,   // Resolved pad levels.
   output logic       o_timer0_wave, // Timer-0 output.
   output logic       o_timer1_wave, // Timer-1 output.
   output logic       o_serial_clk   // Serial clock output.
);
   logic [3:0] cnt_ff = 4'h0; // Wave generator count.
   logic       tgl_ff = 1'h0; // Pattern for floating pads.

   // Peripherals run enabled so their waves reach the pins when routed.
   always @(posedge i_clock) begin
      cnt_ff <= cnt_ff + 4'h1;
      tgl_ff <= ~tgl_ff;
   end
   assign o_timer0_wave = cnt_ff[0];
   assign o_serial_clk  = cnt_ff[1];
   assign o_timer1_wave = cnt_ff[2];

   // A driven pad shows its driver, a pulled pad reads high, a floating one wanders.
   always @* begin
      for (int n = 0; n < 8; n++) begin
         if (n < 6 && i_pad_oe[n % 6]) begin
            o_pad_in[n] = i_pad_out[n % 6];
         end else if (i_pullup_en[n]) begin
            o_pad_in[n] = 1'h1;
         end else begin
            o_pad_in[n] = tgl_ff;
         end
      end
   end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the port-0 pin configuration block.
`timescale 1ns/1ps
`include "port0_pin_config_regs.vh"
module tb_top;
   // ----
   // Stimulus and observed signals.
   // ----
   logic        i_clock = 1'h0, i_rst_b = 1'h0, i_ce = 1'h1;
   logic [9:0]  i_awaddr = 10'h000, i_araddr = 10'h000;
   logic [31:0] i_wdata = 32'h0;
   logic [3:0]  i_wstrb = 4'h0;
   logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
   logic        i_arvalid = 1'h0, i_rready = 1'h0;
   wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   wire [1:0]   o_bresp, o_rresp;
   wire [31:0]  o_rdata;
   wire [7:0]   i_pad_in, o_pullup_en;
   wire [5:0]   o_pad_out, o_pad_oe, o_analog_sel, o_pin_level;
   wire         i_timer0_wave, i_timer1_wave, i_serial_clk;
   wire         o_subosc_in_sel, o_subosc_out_sel;
   int          error_cnt = 0, compares = 0;
   logic        slow = 1'h0;  // Delays the ready of the answer channels.
   logic [31:0] rdv;          // Last read data.
   logic [1:0]  rsp;          // Last response code.
   logic [2:0]  m;            // Expected decoded mode.

   always #50 i_clock = ~i_clock;

   port0_pin_config u_dut (.*);
   port0_pins_model u_pins (.i_clock(i_clock), .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
      .i_pullup_en(o_pullup_en), .o_pad_in(i_pad_in), .o_timer0_wave(i_timer0_wave),
      .o_timer1_wave(i_timer1_wave), .o_serial_clk(i_serial_clk));

   // ----
   // Checking and closing.
   // ----
   task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Expected {analog, enable, driven level} of a pin for a decoded mode.
   function automatic [2:0] exp_pin(input [2:0] md, input b, input w);
      case (md)
         3'h0: exp_pin = 3'h0;
         3'h1: exp_pin = {1'h0, ~b, 1'h0};
         3'h2: exp_pin = 3'h4;
         3'h3: exp_pin = {2'h1, w};
         default: exp_pin = {2'h1, b};
      endcase
   endfunction

   task automatic pin(input int n, input [2:0] md, input w, input b);
      chk("pin", {o_analog_sel[n], o_pad_oe[n], o_pad_oe[n] & o_pad_out[n]}, exp_pin(md, b, w));
   endtask

   // ----
   // AXI4-Lite master: values are looked at on the falling edge, acted on at the rising one.
   // ----
   task automatic wr(input [9:0] a, input [7:0] dt, input [3:0] s);
      logic aw_h, w_h, b_h, bv;
      int n;
      @(posedge i_clock);
      i_awaddr <= a;
      i_wdata <= {24'h000000, dt};
      i_wstrb <= s;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      i_bready <= !slow;
      b_h = 1'h0;
      n = 0;
      while (!b_h && n < 50) begin
         @(negedge i_clock);
         aw_h = i_awvalid && o_awready;
         w_h = i_wvalid && o_wready;
         bv = o_bvalid;
         b_h = bv && i_bready;
         rsp = o_bresp;
         @(posedge i_clock);
         if (aw_h) i_awvalid <= 1'h0;
         if (w_h) i_wvalid <= 1'h0;
         if (bv) i_bready <= !b_h;
         n++;
      end
      if (!b_h) error_cnt++;
   endtask

   task automatic rd(input [9:0] a);
      logic ar_h, r_h, rv;
      int n;
      @(posedge i_clock);
      i_araddr <= a;
      i_arvalid <= 1'h1;
      i_rready <= !slow;
      r_h = 1'h0;
      n = 0;
      while (!r_h && n < 50) begin
         @(negedge i_clock);
         ar_h = i_arvalid && o_arready;
         rv = o_rvalid;
         r_h = rv && i_rready;
         rdv = o_rdata;
         rsp = o_rresp;
         @(posedge i_clock);
         if (ar_h) i_arvalid <= 1'h0;
         if (rv) i_rready <= !r_h;
         n++;
      end
      if (!r_h) error_cnt++;
   endtask

   // Reset for four cycles, then confirm the cleared middle, low and pull-up registers and floating pads.
   task automatic do_reset;
      logic [9:0] a [3];
      a = '{`P0_ADDR_CTRL_MID, `P0_ADDR_CTRL_LOW, `P0_ADDR_PULLUP};
      @(posedge i_clock);
      i_rst_b <= 1'h0;
      repeat (4) @(posedge i_clock);
      i_rst_b <= 1'h1;
      for (int k = 0; k < 3; k++) begin
         rd(a[k]);
         chk("reset", rdv, 32'h0);
      end
      @(negedge i_clock);
      chk("oe", o_pad_oe, 32'h0);
   endtask

   // ----
   // Test sequence.
   // ----
   initial begin
      do_reset;
      wr(`P0_ADDR_PULLUP, 8'hFF, 4'hF);
      rd(`P0_ADDR_PULLUP);
      chk("pullup", rdv, 32'hFF);
      repeat (8) @(posedge i_clock);
      @(negedge i_clock);
      chk("level", o_pin_level, 32'h3F);
      chk("pu_pin", o_pullup_en, 32'hFF);
      rd(`P0_ADDR_PORT_DATA);
      chk("data", rdv, 32'hFF);
      // Every code of the middle fields, with data low and then high plus the pin-5 override.
      for (int d = 0; d < 2; d++) begin
         slow = d[0];
         wr(`P0_ADDR_PORT_DATA, d[0] ? 8'h3F : 8'h00, 4'hF);
         wr(`P0_ADDR_CTRL_HIGH, {7'h00, d[0]}, 4'hF);
         for (int c = 0; c < 8; c++) begin
            wr(`P0_ADDR_CTRL_MID, {c[1:0], c[2:0], c[2:0]}, 4'hF);
            rd(`P0_ADDR_CTRL_MID);
            chk("mid", rdv, {24'h0, c[1:0], c[2:0], c[2:0]});
            @(negedge i_clock);
            pin(3, c[2:0], i_timer0_wave, d[0]);
            pin(4, c[2:0], i_serial_clk, d[0]);
            pin(5, d[0] ? 3'h4 : {1'h0, c[1:0]}, i_timer1_wave, d[0]);
         end
      end
      // Every code of the low fields; the unused top bits read back as zero.
      for (int c = 0; c < 4; c++) begin
         wr(`P0_ADDR_CTRL_LOW, {2'h3, c[1:0], c[1:0], c[1:0]}, 4'hF);
         rd(`P0_ADDR_CTRL_LOW);
         chk("low", rdv, {26'h0, c[1:0], c[1:0], c[1:0]});
         @(negedge i_clock);
         chk("subosc", {o_subosc_out_sel, o_subosc_in_sel}, {2{c == 2}});
         m = (c == 3) ? 3'h4 : (c == 2) ? 3'h0 : c[2:0];
         pin(0, m, 1'h0, 1'h1);
         pin(1, m, 1'h0, 1'h1);
         pin(2, (c == 3) ? 3'h4 : c[2:0], 1'h0, 1'h1);
      end
      // Unmapped place, masked write, then a fresh pull-up pattern.
      wr(10'h328, 8'h55, 4'hF);
      chk("bresp", rsp, `P0_RESP_SLVERR);
      rd(10'h328);
      chk("rresp", rsp, `P0_RESP_SLVERR);
      chk("rdata", rdv, 32'h0);
      wr(`P0_ADDR_PULLUP, 8'h00, 4'hE);
      rd(`P0_ADDR_PULLUP);
      chk("masked", rdv, 32'hFF);
      wr(`P0_ADDR_PULLUP, 8'h5A, 4'hF);
      @(negedge i_clock);
      chk("pu_pin", o_pullup_en, 32'h5A);
      do_reset;
      print_verdict;
   end

   // Cuts a hang short well beyond the few hundred cycles the tests need.
   initial begin
      #2000000;
      error_cnt++;
      print_verdict;
   end
endmodule
